// File: design/option_cfg_pkg.sv
// Option configuration package: bit positions, reset values, bus map.
// Assumes a single 100 MHz system clock domain.
package option_cfg_pkg;
  localparam int unsigned OPT_W = 16;
  // Field positions in the sixteen-bit configuration word
  localparam int unsigned BIT_STOP_WDG = 9;
  localparam int unsigned BIT_BROWNOUT = 8;
  localparam int unsigned BIT_PROTECT = 7;
  localparam int unsigned BIT_OSC_RC = 6;
  localparam int unsigned BIT_NMI_PULL = 3;
  localparam int unsigned BIT_CNT_PULL = 2;
  localparam int unsigned BIT_HW_WDG = 1;
  localparam int unsigned BIT_GUARD = 0;
  // Writable positions; reserved ones are 15:10 and 5:4
  localparam logic [15:0] OPT_USED_MASK = 16'h03cf;
  // Blank content of an unprogrammed part
  localparam logic [15:0] OPT_BLANK = 16'h0000;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_OPT_VALUE = 8'h00;
  localparam logic [7:0] OFS_OPT_PROG = 8'h04;
  localparam logic [7:0] OFS_OPT_STATUS = 8'h08;
  // Status bit positions
  localparam int unsigned ST_PROG_MODE = 0;
  localparam int unsigned ST_REJECT = 1;
  localparam int unsigned ST_MASKED = 2;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: design/option_pin_sync.sv
// Two-flop synchroniser for pin-level inputs.
// Assumes the destination runs on sys_clk.
`timescale 1ns/1ps
module option_pin_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

// File: design/option_byte_config_store.sv
// One-time-programmable configuration store with static option outputs, except the NMI-gated stop_with_watchdog_allow.
// Assumes prog_mode_pin and nmi_pin_level come from package pins; the
// programmer reaches the store over AXI4-Lite only in programming mode.
//
// Behaviour
// [R1] Two configuration bytes, sixteen bits, select the hardware setup.
// [R2] No data or program address; access only during programming mode.
// [R3] Each bit programs once; later changes are refused.
// [R4] Mask-coded parts use fixed bits and cannot be read back.
// [R5] Blank user part holds all zeros.
// [R6] Programmer writes zeros into bits 15:10 and 5:4.
// [R7] Bit 9 allows stop with watchdog when NMI pin is high.
// [R8] Bit 8 enables the brownout detector.
// [R9] Bit 7 blocks external read-out of program memory.
// [R10] Bit 6 selects RC network oscillator, else crystal or clock.
// [R11] Bit 3 enables the NMI pin pull-up.
// [R12] Bit 2 enables the count input pin pull-up.
// [R13] Bit 1 selects the hardware always-on watchdog.
// [R14] Bit 0 enables the clock guard function.
// [R15] Values captured during reset, held static while running.
`timescale 1ns/1ps
module option_byte_config_store #(
  parameter bit MASK_CODED = 1'b0,
  parameter logic [15:0] MASK_VALUE = 16'h0000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Pins
  input wire logic prog_mode_pin,
  input wire logic nmi_pin_level,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Static configuration outputs, except stop_with_watchdog_allow, which also follows the synchronised NMI pin
  output logic stop_with_watchdog_allow,
  output logic brownout_detect_en,
  output logic program_readout_block,
  output logic osc_rc_sel,
  output logic nmi_pullup_en,
  output logic count_input_pullup_en,
  output logic hw_watchdog_sel,
  output logic clock_guard_en
);
  // Synchronised pins
  logic prog_mode_s;
  logic nmi_level_s;

  option_pin_sync #(
    .W(2)
  ) i_option_pin_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .async_in({prog_mode_pin, nmi_pin_level}),
    .sync_out({prog_mode_s, nmi_level_s})
  );

  // Non-volatile cells keep their content through sys_rst
  // [R5] Blank content
  logic [15:0] cell_q = option_cfg_pkg::OPT_BLANK;
  logic [15:0] cell_d;
  logic [15:0] live_q;
  logic capture_q;
  logic reject_q;
  logic reject_d;

  // Write channel state
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;

  // Read channel state
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // Write decode
  wire wr_fire = aw_held_q && w_held_q && !bvalid_q;
  wire wr_is_prog = (aw_addr_q == option_cfg_pkg::OFS_OPT_PROG);
  wire wr_allowed = prog_mode_s && !MASK_CODED;
  wire [15:0] wr_bits = {w_strb_q[1] ? w_data_q[15:8] : 8'h00,
                         w_strb_q[0] ? w_data_q[7:0] : 8'h00};
  // Bits that try to return to zero cannot be honoured
  wire wr_clears = |(cell_q & ~wr_bits);
  wire wr_reserved = |(wr_bits & ~option_cfg_pkg::OPT_USED_MASK);
  wire wr_ok = wr_fire && wr_is_prog && wr_allowed && !wr_clears
               && !wr_reserved && (w_strb_q[1:0] == 2'h3);

  // [R3] Program once
  assign cell_d = wr_ok ? (cell_q | wr_bits) : cell_q;
  assign reject_d = wr_fire && wr_is_prog && !wr_ok;

  // [R3] Cells survive reset
  always_ff @(posedge sys_clk) begin
    cell_q <= cell_d;
  end

  // [R15] Capture at reset release
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      capture_q <= 1'b1;
      live_q <= option_cfg_pkg::OPT_BLANK;
    end else begin
      capture_q <= 1'b0;
      if (capture_q) begin
        // [R4] Mask value fixed
        live_q <= MASK_CODED ? MASK_VALUE : cell_q;
      end
    end
  end

  // Write address and data taken in either order
  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready = !w_held_q;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_held_q) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_held_q) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // [R2] Outside programming mode every write errors; status reads still answer OKAY
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= option_cfg_pkg::RESP_OKAY;
      reject_q <= 1'b0;
    end else begin
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? option_cfg_pkg::RESP_OKAY
                         : option_cfg_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      // Sticky until the next accepted programming write
      if (reject_d) begin
        reject_q <= 1'b1;
      end else if (wr_ok) begin
        reject_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Read decode
  wire rd_fire = s_axi_arvalid && !rvalid_q;
  wire rd_val = (s_axi_araddr == option_cfg_pkg::OFS_OPT_VALUE);
  wire rd_stat = (s_axi_araddr == option_cfg_pkg::OFS_OPT_STATUS);
  // [R4] No read-back on masked parts
  wire rd_val_ok = rd_val && prog_mode_s && !MASK_CODED;
  wire [31:0] status_word = {29'h0000_0000, MASK_CODED, reject_q,
                             prog_mode_s};
  wire [31:0] rd_word = rd_val_ok ? {16'h0000, cell_q}
                      : rd_stat ? status_word : 32'h0000_0000;
  wire rd_okay = rd_val_ok || rd_stat;

  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= option_cfg_pkg::RESP_OKAY;
    end else begin
      if (rd_fire) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= rd_okay ? option_cfg_pkg::RESP_OKAY
                           : option_cfg_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // [R1] Settings decode
  // [R7] Stop with watchdog
  assign stop_with_watchdog_allow =
    live_q[option_cfg_pkg::BIT_STOP_WDG] && nmi_level_s;
  // [R8] Brownout detector
  assign brownout_detect_en = live_q[option_cfg_pkg::BIT_BROWNOUT];
  // [R9] Read-out block
  assign program_readout_block = live_q[option_cfg_pkg::BIT_PROTECT];
  // [R10] Oscillator kind
  assign osc_rc_sel = live_q[option_cfg_pkg::BIT_OSC_RC];
  // [R11] NMI pull-up
  assign nmi_pullup_en = live_q[option_cfg_pkg::BIT_NMI_PULL];
  // [R12] Count input pull-up
  assign count_input_pullup_en = live_q[option_cfg_pkg::BIT_CNT_PULL];
  // [R13] Watchdog kind
  assign hw_watchdog_sel = live_q[option_cfg_pkg::BIT_HW_WDG];
  // [R14] Clock guard
  assign clock_guard_en = live_q[option_cfg_pkg::BIT_GUARD];
endmodule

// File: tb/option_cfg_props.sv
// Checker for the option store: bus answers, refusals, static options.
// Bound to every store instance; one clock domain.
`timescale 1ns/1ps
module option_cfg_props (
  // Clock, reset, pins
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic prog_mode_pin,
  input wire logic nmi_pin_level,
  // Bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Options
  input wire logic stop_with_watchdog_allow,
  input wire logic brownout_detect_en,
  input wire logic osc_rc_sel,
  input wire logic clock_guard_en
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready;
  wire rsv_hit = |(s_axi_wdata[15:0] & ~option_cfg_pkg::OPT_USED_MASK);
  a_write_answer: assert property (wr_both |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  a_noprog_refused: assert property (
    (!prog_mode_pin)[*4] ##0 wr_both |->
    ##2 s_axi_bresp == option_cfg_pkg::RESP_SLVERR)
    else $error("write outside programming mode taken");
  a_reserved_refused: assert property (
    wr_both && rsv_hit |-> ##2 s_axi_bresp == option_cfg_pkg::RESP_SLVERR)
    else $error("reserved bit write taken");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_stop_needs_nmi: assert property (
    stop_with_watchdog_allow |-> $past(nmi_pin_level, 2))
    else $error("stop allowed without nmi high");
  a_opts_static: assert property (
    $past(sys_rst, 2) ||
    $stable({brownout_detect_en, osc_rc_sel, clock_guard_en}))
    else $error("option output changed while running");
endmodule
bind option_byte_config_store option_cfg_props i_option_cfg_props (.*);

// File: tb/option_prog_tool.sv
// Programming tool model: bus master, one access at a time.
// Tasks are called from the bench just after a rising edge.
`timescale 1ns/1ps
module option_prog_tool (
  // Clock
  input wire logic sys_clk,
  // Bus
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
  end
  // Data driven as given; reserved bits are not masked here
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s = 4'hf);
    logic done;
    done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!done) begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      done = s_axi_bvalid;
    end
    s_axi_bready <= 1'b0;
    // Let an edge pass so a following call never re-drives in this step
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    logic done;
    done = 1'b0;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    while (!done) begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      done = s_axi_rvalid;
    end
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask
endmodule

// File: tb/option_byte_config_store_test.sv
// Bench for the option store: tool model drives the bus.
// Expected answers are queued and compared by a monitor.
`timescale 1ns/1ps
module option_byte_config_store_test;
  localparam logic [15:0] MV = 16'h02c5;
  localparam logic [1:0] OK = option_cfg_pkg::RESP_OKAY;
  localparam logic [1:0] ER = option_cfg_pkg::RESP_SLVERR;
  logic sys_clk = 1'b0, sys_rst = 1'b1;
  logic prog_mode_pin = 1'b0, nmi_pin_level = 1'b0;
  wire [7:0] s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0] s_axi_wstrb;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  wire s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  wire s_axi_rvalid, s_axi_rready;
  wire stop_with_watchdog_allow, brownout_detect_en, program_readout_block;
  wire osc_rc_sel, nmi_pullup_en, count_input_pullup_en;
  wire hw_watchdog_sel, clock_guard_en;
  wire [7:0] m;
  wire [31:0] mrd;
  wire [1:0] mbr, mrr;
  wire mbv, mrv;
  wire [7:0] opt = {stop_with_watchdog_allow, brownout_detect_en,
    program_readout_block, osc_rc_sel, nmi_pullup_en,
    count_input_pullup_en, hw_watchdog_sel, clock_guard_en};
  logic [33:0] expq[$];
  logic [15:0] acc;
  logic [31:0] v;
  logic [7:0] want;
  logic [33:0] mq[$];
  int mismatches = 0, checks_done = 0;
  option_prog_tool i_option_prog_tool (.*);
  option_byte_config_store i_option_byte_config_store (.*);
  option_byte_config_store #(.MASK_CODED(1'b1), .MASK_VALUE(MV))
    i_option_byte_config_store_m (.s_axi_awready(), .s_axi_wready(),
    .s_axi_bresp(mbr), .s_axi_bvalid(mbv), .s_axi_arready(),
    .s_axi_rdata(mrd), .s_axi_rresp(mrr), .s_axi_rvalid(mrv),
    .stop_with_watchdog_allow(m[7]),
    .brownout_detect_en(m[6]), .program_readout_block(m[5]),
    .osc_rc_sel(m[4]), .nmi_pullup_en(m[3]),
    .count_input_pullup_en(m[2]), .hw_watchdog_sel(m[1]),
    .clock_guard_en(m[0]), .*);
  initial forever #5 sys_clk = ~sys_clk;
  task automatic cmp(string n, logic [33:0] e, logic [33:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr_exp(logic [31:0] d, logic [1:0] r,
    logic [3:0] s = 4'hf, logic [7:0] a = option_cfg_pkg::OFS_OPT_PROG);
    expq.push_back({r, 32'h0});
    i_option_prog_tool.wr(a, d, s);
  endtask
  task automatic rd_exp(logic [7:0] a, logic [1:0] r, logic [31:0] d);
    expq.push_back({r, d});
    // Masked part answers status only; its reject flag is set by then
    if (a == option_cfg_pkg::OFS_OPT_STATUS)
      mq.push_back({OK, 29'h0, 2'h3, prog_mode_pin});
    else
      mq.push_back({ER, 32'h0});
    i_option_prog_tool.rd(a);
  endtask
  always @(posedge sys_clk) begin
    if (s_axi_bvalid && s_axi_bready)
      cmp("bresp", expq.pop_front(), {s_axi_bresp, 32'h0});
    if (s_axi_rvalid && s_axi_rready)
      cmp("read", expq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (mbv && s_axi_bready)
      cmp("mask bresp", {ER, 32'h0}, {mbr, 32'h0});
    if (mrv && s_axi_rready)
      cmp("mask read", mq.pop_front(), {mrr, mrd});
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    close_out();
  end
  initial begin
    void'($urandom(90101));
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    cmp("blank", 34'h0, {26'h0, opt});
    cmp("mask", {26'h0, 1'b0, MV[8:6], MV[3:0]}, {26'h0, m});
    $display("test blank done");
    wr_exp(32'h1, ER);
    rd_exp(8'h00, ER, 32'h0);
    rd_exp(8'h08, OK, 32'h2);
    $display("test locked done");
    prog_mode_pin <= 1'b1;
    nmi_pin_level <= 1'b1;
    repeat (3) @(posedge sys_clk);
    cmp("nmi", {26'h0, MV[9], MV[8:6], MV[3:0]}, {26'h0, m});
    wr_exp(32'h1, OK);
    rd_exp(8'h00, OK, 32'h1);
    wr_exp(32'h3, ER, 4'h1);
    wr_exp(32'h3, ER, 4'hf, 8'h00);
    rd_exp(8'h00, OK, 32'h1);
    wr_exp(32'h0, ER);
    wr_exp(32'h401, ER);
    wr_exp(32'h11, ER);
    rd_exp(8'h08, OK, 32'h3);
    rd_exp(8'h0c, ER, 32'h0);
    $display("test program done");
    acc = 16'h0201;
    repeat (4) begin
      v = $urandom;
      acc = acc | (v[15:0] & option_cfg_pkg::OPT_USED_MASK);
      wr_exp({v[31:16], acc}, OK);
      rd_exp(8'h00, OK, {16'h0, acc});
    end
    cmp("held", 34'h0, {26'h0, opt});
    $display("test random done");
    sys_rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    want = {acc[9], acc[8:6], acc[3:0]};
    cmp("recapture", {26'h0, want}, {26'h0, opt});
    wr_exp(32'h0, ER);
    wr_exp({16'h0, option_cfg_pkg::OPT_USED_MASK}, OK);
    rd_exp(8'h00, OK, {16'h0, option_cfg_pkg::OPT_USED_MASK});
    cmp("static", {26'h0, want}, {26'h0, opt});
    nmi_pin_level <= 1'b0;
    repeat (3) @(posedge sys_clk);
    want[7] = 1'b0;
    cmp("nmi low", {26'h0, want}, {26'h0, opt});
    $display("test reset done");
    close_out();
  end
endmodule
